// >>> oce_pkg.sv
// shared constants and carrier types of the output condition evaluator
package oce_pkg;

  // clock and time base
  localparam int unsigned OCE_CLK_PERIOD_NS = 40;
  localparam int unsigned OCE_NS_PER_MS = 1000000;
  localparam int unsigned OCE_CYC_PER_MS = OCE_NS_PER_MS / OCE_CLK_PERIOD_NS;
  localparam int unsigned OCE_TIME_MS_W = 14;
  localparam int unsigned OCE_PRE_W = 24;

  // data operand geometry: characters are hex nibbles
  localparam int unsigned OCE_MAX_CHARS = 32;
  localparam int unsigned OCE_LEN_W = 6;
  localparam int unsigned OCE_PAT_WORDS = OCE_MAX_CHARS / 8;
  localparam int unsigned OCE_COUNT_W = 10;
  localparam int unsigned OCE_ERR_MAX = 6;

  // register map, byte addresses
  localparam logic [7:0] OCE_REG_CTRL = 8'h00;
  localparam logic [7:0] OCE_REG_TIME = 8'h04;
  localparam logic [7:0] OCE_REG_COND_A = 8'h08;
  localparam logic [7:0] OCE_REG_COND_B = 8'h0c;
  localparam logic [7:0] OCE_REG_ERR_LO = 8'h10;
  localparam logic [7:0] OCE_REG_ERR_HI = 8'h14;
  localparam logic [7:0] OCE_REG_STATUS = 8'h18;
  localparam logic [3:0] OCE_PAGE_PAT_A = 4'h2;
  localparam logic [7:0] OCE_REG_WILD_A = 8'h30;
  localparam logic [3:0] OCE_PAGE_PAT_B = 4'h4;
  localparam logic [7:0] OCE_REG_WILD_B = 8'h50;

  // output timing selector codes
  localparam logic [7:0] OCE_TIMING_NORMAL = 8'h31;
  localparam logic [7:0] OCE_TIMING_ERROR = 8'h32;

  // field positions inside ERR_HI
  localparam int unsigned OCE_ERR_CNT_LSB = 16;

  // comparison operators
  typedef enum logic [1:0] {
    OCE_OP_EQ,
    OCE_OP_NE,
    OCE_OP_GE,
    OCE_OP_LE
  } oce_op_t;

  // bit 10 or_sel, 9 en_b, 8 en_a, 7:0 timing code
  typedef struct packed {
    logic or_sel;
    logic en_b;
    logic en_a;
    logic [7:0] timing;
  } oce_ctrl_t;

  // bits 18:9 const, 8:3 length, 2:1 op, 0 operand select (1 = tag count)
  typedef struct packed {
    logic [OCE_COUNT_W-1:0] konst;
    logic [OCE_LEN_W-1:0] len;
    oce_op_t op;
    logic sel_count;
  } oce_cond_t;

  // completion report of one executed command
  typedef struct packed {
    logic done;
    logic error;
    logic [7:0] err_code;
    logic [OCE_COUNT_W-1:0] tag_count;
    logic [OCE_LEN_W-1:0] len;
  } oce_cmd_t;

  localparam oce_ctrl_t OCE_CTRL_RST = '0;
  localparam oce_cond_t OCE_COND_RST = '0;
  localparam logic [OCE_TIME_MS_W-1:0] OCE_TIME_RST = '0;

endpackage : oce_pkg

// >>> oce_cond_eval.sv
// one condition: data pattern match or tag count comparison
`timescale 1ns/100ps
module oce_cond_eval import oce_pkg::*; #(
  parameter int unsigned MAXC = OCE_MAX_CHARS
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire oce_cond_t cfg_i,
  input wire logic [4*MAXC-1:0] pat_i,
  input wire logic [MAXC-1:0] wild_i,
  input wire logic [4*MAXC-1:0] data_i,
  input wire logic [MAXC-1:0] comma_i,
  input wire logic [OCE_LEN_W-1:0] len_i,
  input wire logic [OCE_COUNT_W-1:0] count_i,
  output logic result_o
);

  logic [MAXC-1:0] char_ok;
  logic data_eq;
  logic data_res;
  logic count_res;

  // per character: beyond length, wildcard, or equal nibble
  // a comma position only passes through the wildcard
  for (genvar i = 0; i < MAXC; i++) begin : g_char
    assign char_ok[i] = (i >= int'(len_i)) || wild_i[i] ||
      (!comma_i[i] && (pat_i[4*i +: 4] == data_i[4*i +: 4]));
  end

  assign data_eq = (cfg_i.len == len_i) && (&char_ok);
  // data supports only equality and inequality
  assign data_res = (cfg_i.op == OCE_OP_EQ) ? data_eq :
                    (cfg_i.op == OCE_OP_NE) ? !data_eq : 1'b0;
  assign count_res = (cfg_i.op == OCE_OP_EQ) ? (count_i == cfg_i.konst) :
                     (cfg_i.op == OCE_OP_NE) ? (count_i != cfg_i.konst) :
                     (cfg_i.op == OCE_OP_GE) ? (count_i >= cfg_i.konst) :
                     (count_i <= cfg_i.konst);
  assign result_o = cfg_i.sel_count ? count_res : data_res;

  a_len_mismatch: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    (!cfg_i.sel_count && cfg_i.len != len_i) |-> !result_o)
    else $error("data condition true despite length mismatch");

  a_data_ops: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    (!cfg_i.sel_count && cfg_i.op inside {OCE_OP_GE, OCE_OP_LE})
      |-> !result_o)
    else $error("ordering compare accepted on read data");

  a_count_order: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    (cfg_i.sel_count && cfg_i.op == OCE_OP_GE && count_i < cfg_i.konst)
      |-> !result_o)
    else $error("tag count at least compare wrong");

endmodule : oce_cond_eval

// >>> oce_output_eval.sv
// programmable output port driven by end-of-command condition evaluation
//
// Functional notes
// - normal mode operand is read data or tag count, chosen per condition
// - read data supports only equal and not-equal
// - tag count supports equal, not-equal, at least, at most
// - pattern and read data of unequal length never match
// - full tag info data: comma positions need wildcard positions
// - two conditions combine by AND or OR to decide the output
// - normal mode with no condition asserts after every normal end
// - error mode data operand is the first two error code characters
// - error mode: equal means code in list, not-equal means absent
// - error mode with no condition asserts after every error end
// - timing code 31 selects normal mode, 32 selects error mode
// - output holds the set time in ms; zero holds to next evaluation
`timescale 1ns/100ps
module oce_output_eval import oce_pkg::*; #(
  parameter int unsigned CYC_PER_MS = OCE_CYC_PER_MS
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire oce_cmd_t cmd_i,
  input wire logic [4*OCE_MAX_CHARS-1:0] rd_data_i,
  input wire logic [OCE_MAX_CHARS-1:0] rd_comma_i,
  output logic out_port_o
);

  localparam logic [OCE_PRE_W-1:0] PRE_LAST = OCE_PRE_W'(CYC_PER_MS - 1);

  oce_ctrl_t ctrl;
  logic [OCE_TIME_MS_W-1:0] time_ms;
  oce_cond_t cond_a;
  oce_cond_t cond_b;
  logic [7:0] err_list [OCE_ERR_MAX];
  logic [2:0] err_cnt;
  logic [31:0] pat_a [OCE_PAT_WORDS];
  logic [31:0] pat_b [OCE_PAT_WORDS];
  logic [31:0] wild_a;
  logic [31:0] wild_b;
  logic last_result;
  logic hold_timed;
  logic [OCE_TIME_MS_W-1:0] ms_left;
  logic [OCE_PRE_W-1:0] pre;

  // address decode
  wire wr_ctrl = wr_i && addr_i == OCE_REG_CTRL;
  wire wr_time = wr_i && addr_i == OCE_REG_TIME;
  wire wr_cond_a = wr_i && addr_i == OCE_REG_COND_A;
  wire wr_cond_b = wr_i && addr_i == OCE_REG_COND_B;
  wire wr_err_lo = wr_i && addr_i == OCE_REG_ERR_LO;
  wire wr_err_hi = wr_i && addr_i == OCE_REG_ERR_HI;
  wire wr_wild_a = wr_i && addr_i == OCE_REG_WILD_A;
  wire wr_wild_b = wr_i && addr_i == OCE_REG_WILD_B;
  wire in_pat_a = addr_i[7:4] == OCE_PAGE_PAT_A;
  wire in_pat_b = addr_i[7:4] == OCE_PAGE_PAT_B;
  wire [1:0] pat_idx = addr_i[3:2];
  wire [2:0] cnt_req = wdata_i[OCE_ERR_CNT_LSB +: 3];
  // a count above six is clamped so stale slots never join the match
  wire [2:0] cnt_clamped = (cnt_req > 3'(OCE_ERR_MAX)) ?
                           3'(OCE_ERR_MAX) : cnt_req;

  // register writes
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ctrl <= OCE_CTRL_RST;
      time_ms <= OCE_TIME_RST;
      cond_a <= OCE_COND_RST;
      cond_b <= OCE_COND_RST;
      err_cnt <= '0;
      wild_a <= '0;
      wild_b <= '0;
    end else begin
      if (wr_ctrl) ctrl <= oce_ctrl_t'(wdata_i[10:0]);
      if (wr_time) time_ms <= wdata_i[OCE_TIME_MS_W-1:0];
      if (wr_cond_a) cond_a <= oce_cond_t'(wdata_i[18:0]);
      if (wr_cond_b) cond_b <= oce_cond_t'(wdata_i[18:0]);
      if (wr_err_hi) err_cnt <= cnt_clamped;
      if (wr_wild_a) wild_a <= wdata_i;
      if (wr_wild_b) wild_b <= wdata_i;
    end
  end

  // pattern words and error codes are data, not control; no reset needed
  always_ff @(posedge clk_sys_i) begin
    if (wr_i && in_pat_a) pat_a[pat_idx] <= wdata_i;
    if (wr_i && in_pat_b) pat_b[pat_idx] <= wdata_i;
    if (wr_err_lo) begin
      for (int k = 0; k < 4; k++) err_list[k] <= wdata_i[8*k +: 8];
    end
    if (wr_err_hi) begin
      err_list[4] <= wdata_i[7:0];
      err_list[5] <= wdata_i[15:8];
    end
  end

  // condition evaluators
  wire [4*OCE_MAX_CHARS-1:0] pat_a_flat = {pat_a[3], pat_a[2], pat_a[1],
                                           pat_a[0]};
  wire [4*OCE_MAX_CHARS-1:0] pat_b_flat = {pat_b[3], pat_b[2], pat_b[1],
                                           pat_b[0]};
  logic res_a;
  logic res_b;

  oce_cond_eval #(.MAXC(OCE_MAX_CHARS)) u_cond_a (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .cfg_i(cond_a),
    .pat_i(pat_a_flat),
    .wild_i(wild_a),
    .data_i(rd_data_i),
    .comma_i(rd_comma_i),
    .len_i(cmd_i.len),
    .count_i(cmd_i.tag_count),
    .result_o(res_a)
  );

  oce_cond_eval #(.MAXC(OCE_MAX_CHARS)) u_cond_b (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .cfg_i(cond_b),
    .pat_i(pat_b_flat),
    .wild_i(wild_b),
    .data_i(rd_data_i),
    .comma_i(rd_comma_i),
    .len_i(cmd_i.len),
    .count_i(cmd_i.tag_count),
    .result_o(res_b)
  );

  // mode selection and evaluation events
  wire mode_normal = ctrl.timing == OCE_TIMING_NORMAL;
  wire mode_error = ctrl.timing == OCE_TIMING_ERROR;
  wire ev_normal = cmd_i.done && !cmd_i.error && mode_normal;
  wire ev_error = cmd_i.done && cmd_i.error && mode_error;
  wire ev_any = ev_normal || ev_error;

  // normal end result; no condition means unconditional
  wire comb_ab = ctrl.or_sel ? (res_a || res_b) : (res_a && res_b);
  wire normal_res = !ctrl.en_a ? 1'b1 :
                    !ctrl.en_b ? res_a : comb_ab;

  // error end result: prefix looked up in the code list
  logic [OCE_ERR_MAX-1:0] err_hit;
  for (genvar j = 0; j < OCE_ERR_MAX; j++) begin : g_err
    assign err_hit[j] = (3'(j) < err_cnt) &&
                        (err_list[j] == cmd_i.err_code);
  end
  wire err_match = |err_hit;
  // the operand select of condition A is ignored here: no tag count
  wire error_cmp = (cond_a.op == OCE_OP_EQ) ? err_match :
                   (cond_a.op == OCE_OP_NE) ? !err_match : 1'b0;
  wire error_res = !ctrl.en_a ? 1'b1 : error_cmp;
  wire eval_res = ev_normal ? normal_res : error_res;

  // hold timer: ms prescaler plus ms down counter
  // the prescaler restarts on a load and at each ms tick, so a pulse lasts whole
  // milliseconds counted from the evaluation edge
  wire ms_tick = pre == PRE_LAST;
  wire expire = out_port_o && hold_timed && ms_tick &&
                ms_left == OCE_TIME_MS_W'(1);
  wire mode_off = !mode_normal && !mode_error;
  wire next_out = ev_any ? eval_res :
                  (mode_off || expire) ? 1'b0 : out_port_o;
  wire load = ev_any && eval_res;
  wire [OCE_PRE_W-1:0] next_pre = (load || ms_tick) ? '0 : pre + 1'b1;
  wire [OCE_TIME_MS_W-1:0] next_ms = load ? time_ms :
    (ms_tick && ms_left != '0) ? ms_left - 1'b1 : ms_left;

  // output and timer state
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      out_port_o <= 1'b0;
      last_result <= 1'b0;
      hold_timed <= 1'b0;
      ms_left <= '0;
      pre <= '0;
    end else begin
      out_port_o <= next_out;
      pre <= next_pre;
      ms_left <= next_ms;
      if (ev_any) last_result <= eval_res;
      if (load) hold_timed <= time_ms != '0;
    end
  end

  // read data mux; unmapped addresses read zero
  // status: [29:16] ms remaining, [1] last result, [0] port level
  wire [31:0] status_word = {2'b00, ms_left, 14'h0000, last_result,
                            out_port_o};
  wire [31:0] rd_mux =
    (addr_i == OCE_REG_CTRL) ? {21'h0, ctrl} :
    (addr_i == OCE_REG_TIME) ? {18'h0, time_ms} :
    (addr_i == OCE_REG_COND_A) ? {13'h0, cond_a} :
    (addr_i == OCE_REG_COND_B) ? {13'h0, cond_b} :
    (addr_i == OCE_REG_ERR_LO) ?
      {err_list[3], err_list[2], err_list[1], err_list[0]} :
    (addr_i == OCE_REG_ERR_HI) ?
      {13'h0, err_cnt, err_list[5], err_list[4]} :
    (addr_i == OCE_REG_STATUS) ? status_word :
    (addr_i == OCE_REG_WILD_A) ? wild_a :
    (addr_i == OCE_REG_WILD_B) ? wild_b :
    in_pat_a ? pat_a[pat_idx] :
    in_pat_b ? pat_b[pat_idx] : 32'h0000_0000;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) rdata_o <= '0;
    else rdata_o <= rd_i ? rd_mux : '0;
  end

  // checks
  sequence s_normal_end;
    cmd_i.done && !cmd_i.error && mode_normal;
  endsequence

  sequence s_error_end;
    cmd_i.done && cmd_i.error && mode_error;
  endsequence

  // a true evaluation that starts a timed pulse
  sequence s_timed_load;
    load && time_ms != '0;
  endsequence

  a_normal_nocond: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i) (s_normal_end and !ctrl.en_a) |=> out_port_o)
    else $error("normal end without condition did not assert");

  a_error_nocond: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i) (s_error_end and !ctrl.en_a) |=> out_port_o)
    else $error("error end without condition did not assert");

  a_single_cond: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    (s_normal_end and ctrl.en_a && !ctrl.en_b)
      |=> out_port_o == $past(res_a))
    else $error("single condition drives the wrong level");

  a_and_or: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    (s_normal_end and ctrl.en_a && ctrl.en_b)
      |=> out_port_o == $past(ctrl.or_sel ? (res_a || res_b) :
                              (res_a && res_b)))
    else $error("combined conditions drive the wrong level");

  a_err_list: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    (s_error_end and ctrl.en_a && cond_a.op == OCE_OP_NE && err_match)
      |=> !out_port_o)
    else $error("listed error code passed an unmatched test");

  a_err_match: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    (s_error_end and ctrl.en_a && cond_a.op == OCE_OP_EQ)
      |=> out_port_o == $past(err_match))
    else $error("matched error test gave the wrong level");

  a_err_count: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i) err_cnt <= 3'(OCE_ERR_MAX))
    else $error("error list count above six");

  a_timed_start: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    s_timed_load |=> out_port_o && hold_timed && ms_left == $past(time_ms))
    else $error("timed pulse did not start with the set time");

  a_timed_end: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i) (expire && !ev_any) |=> !out_port_o)
    else $error("timed pulse outlived its set time");

  a_other_end: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    (cmd_i.done && !ev_any && !mode_off && !expire) |=> $stable(out_port_o))
    else $error("ignored completion changed the output");

  a_false_clear: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i) (ev_any && !eval_res) |=> !out_port_o)
    else $error("false evaluation left the output on");

  a_mode_off: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i) mode_off |=> !out_port_o)
    else $error("output active with no evaluating timing code");

  a_hold_zero: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    (out_port_o && !hold_timed && !ev_any && !mode_off) |=> out_port_o)
    else $error("zero time hold dropped before next evaluation");

  a_hold_edge: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    $fell(out_port_o) |-> $past(ev_any || expire || mode_off))
    else $error("output fell without evaluation or expiry");

endmodule : oce_output_eval

// >>> oce_equip_model.sv
// model of the external equipment that watches the output port
`timescale 1ns/100ps
module oce_equip_model (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic line_i,
  output logic [15:0] width_o
);
  logic [15:0] run;

  // measures each high pulse in clock cycles; a pulse that never ends is
  // not reported, so a held level must be checked on the line itself
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      run <= 16'h0000;
      width_o <= 16'h0000;
    end else if (line_i) begin
      run <= run + 16'h0001;
    end else begin
      if (run != 16'h0000) begin
        width_o <= run;
      end
      run <= 16'h0000;
    end
  end
endmodule : oce_equip_model

// >>> oce_output_eval_bench.sv
// self-checking bench of the output condition evaluator
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module oce_output_eval_bench import oce_pkg::*;;
  localparam int unsigned CPM = 4;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  oce_cmd_t cmd_i = '0;
  logic [127:0] rd_data_i = '0;
  logic [31:0] rd_comma_i = '0;
  logic out_port_o;
  logic [15:0] width;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  logic [1:0] op;
  logic exp_v;
  logic [9:0] tv[3] = '{10'd9, 10'd10, 10'd11};
  logic [9:0] bv[3] = '{10'd7, 10'd3, 10'd5};

  // short ms so pulse widths stay a few cycles long
  oce_output_eval #(.CYC_PER_MS(CPM)) uut (.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .cmd_i(cmd_i), .rd_data_i(rd_data_i),
    .rd_comma_i(rd_comma_i), .out_port_o(out_port_o));
  oce_equip_model equip (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .line_i(out_port_o), .width_o(width));

  always #20 clk_sys_i = ~clk_sys_i;

  task automatic end_of_test;
    if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  // a hang counts as a mismatch; the run needs well under a thousand cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr

  // read data is looked at only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 `CHK(rdata_o, e)
  endtask : rd

  // one command completion, then the port level after the evaluation
  task automatic ev(input logic er, input logic [7:0] code,
    input logic [9:0] tc, input logic [5:0] ln, input logic [31:0] dat,
    input logic [31:0] cm, input logic e);
    @(posedge clk_sys_i);
    cmd_i <= '{done: 1'b1, error: er, err_code: code, tag_count: tc,
      len: ln};
    rd_data_i <= {96'h0, dat};
    rd_comma_i <= cm;
    @(posedge clk_sys_i);
    cmd_i.done <= 1'b0;
    #1 `CHK(out_port_o, e)
  endtask : ev

  function automatic logic count_cmp(input logic [1:0] o,
    input logic [9:0] t,
    input logic [9:0] k);
    case (o)
      2'd0: return t == k;
      2'd1: return t != k;
      2'd2: return t >= k;
      default: return t <= k;
    endcase
  endfunction : count_cmp

  initial begin
    repeat (16) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    #1 `CHK(out_port_o, 1'b0)
    rd(OCE_REG_CTRL, 32'h0);
    rd(OCE_REG_TIME, 32'h0);
    rd(OCE_REG_COND_A, 32'h0);
    rd(8'h1c, 32'h0);
    // no condition, one ms pulse
    wr(OCE_REG_CTRL, 32'h00000031);
    wr(OCE_REG_TIME, 32'h00000001);
    rd(OCE_REG_CTRL, 32'h00000031);
    ev(1'b0, 8'h00, 10'd0, 6'd0, 32'h0, 32'h0, 1'b1);
    rd(OCE_REG_STATUS, 32'h00010003);
    repeat (CPM + 4) @(posedge clk_sys_i);
    `CHK(width, 16'(CPM))
    `CHK(out_port_o, 1'b0)
    // zero time holds; error ends are ignored in normal mode
    wr(OCE_REG_TIME, 32'h0);
    ev(1'b0, 8'h00, 10'd0, 6'd0, 32'h0, 32'h0, 1'b1);
    ev(1'b1, 8'h70, 10'd0, 6'd0, 32'h0, 32'h0, 1'b1);
    repeat (10) @(posedge clk_sys_i);
    `CHK(out_port_o, 1'b1)
    rd(OCE_REG_STATUS, 32'h00000003);
    // tag count, every operator around the constant 10
    wr(OCE_REG_CTRL, 32'h00000131);
    for (int o = 0; o < 4; o++) begin
      op = 2'(o);
      wr(OCE_REG_COND_A, {13'h0, 10'd10, 6'd0, op, 1'b1});
      for (int i = 0; i < 3; i++) begin
        exp_v = count_cmp(op, tv[i], 10'd10);
        ev(1'b0, 8'h00, tv[i], 6'd0, 32'h0, 32'h0, exp_v);
      end
    end
    // data pattern of eight chars, chars 4 to 7 wild
    wr(8'h20, 32'h87654321);
    wr(OCE_REG_WILD_A, 32'h000000f0);
    wr(OCE_REG_COND_A, 32'h00000040);
    ev(1'b0, 8'h00, 10'd0, 6'd8, 32'habcd4321, 32'h0, 1'b1);
    ev(1'b0, 8'h00, 10'd0, 6'd8, 32'habcd4331, 32'h0, 1'b0);
    ev(1'b0, 8'h00, 10'd0, 6'd7, 32'habcd4321, 32'h0, 1'b0);
    ev(1'b0, 8'h00, 10'd0, 6'd8, 32'hab0d4321, 32'h20, 1'b1);
    ev(1'b0, 8'h00, 10'd0, 6'd8, 32'habcd4321, 32'h4, 1'b0);
    wr(OCE_REG_COND_A, 32'h00000042);
    ev(1'b0, 8'h00, 10'd0, 6'd8, 32'habcd4321, 32'h0, 1'b0);
    ev(1'b0, 8'h00, 10'd0, 6'd8, 32'habcd4322, 32'h0, 1'b1);
    wr(OCE_REG_COND_A, 32'h00000044);
    ev(1'b0, 8'h00, 10'd0, 6'd8, 32'habcd4321, 32'h0, 1'b0);
    // count equal to 7 joined with count not equal to 3
    wr(OCE_REG_COND_A, 32'h00000e01);
    wr(OCE_REG_COND_B, 32'h00000603);
    for (int i = 0; i < 3; i++) begin
      wr(OCE_REG_CTRL, 32'h00000331);
      ev(1'b0, 8'h00, bv[i], 6'd0, 32'h0, 32'h0, bv[i] == 7);
      wr(OCE_REG_CTRL, 32'h00000731);
      exp_v = bv[i] == 10'd7 || bv[i] != 10'd3;
      ev(1'b0, 8'h00, bv[i], 6'd0, 32'h0, 32'h0, exp_v);
    end
    // error mode without a condition, normal ends ignored
    wr(OCE_REG_CTRL, 32'h00000032);
    ev(1'b1, 8'h99, 10'd0, 6'd0, 32'h0, 32'h0, 1'b1);
    ev(1'b0, 8'h00, 10'd0, 6'd0, 32'h0, 32'h0, 1'b1);
    // error code list, first three then all six entries
    wr(OCE_REG_ERR_LO, 32'h73727170);
    wr(OCE_REG_ERR_HI, 32'h00037574);
    wr(OCE_REG_COND_A, 32'h0);
    wr(OCE_REG_CTRL, 32'h00000132);
    ev(1'b1, 8'h71, 10'd0, 6'd0, 32'h0, 32'h0, 1'b1);
    ev(1'b1, 8'h73, 10'd0, 6'd0, 32'h0, 32'h0, 1'b0);
    wr(OCE_REG_ERR_HI, 32'h00067574);
    rd(OCE_REG_ERR_HI, 32'h00067574);
    ev(1'b1, 8'h75, 10'd0, 6'd0, 32'h0, 32'h0, 1'b1);
    wr(OCE_REG_COND_A, 32'h00000002);
    ev(1'b1, 8'h76, 10'd0, 6'd0, 32'h0, 32'h0, 1'b1);
    ev(1'b1, 8'h70, 10'd0, 6'd0, 32'h0, 32'h0, 1'b0);
    ev(1'b1, 8'h76, 10'd0, 6'd0, 32'h0, 32'h0, 1'b1);
    // leaving the evaluated modes drops the port
    wr(OCE_REG_CTRL, 32'h0);
    @(posedge clk_sys_i);
    #1 `CHK(out_port_o, 1'b0)
    end_of_test();
  end
endmodule : oce_output_eval_bench
